/* bmpm_pkg.sv */
// Constants and types shared by the power-mode controller
package bmpm_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CUR_PERIOD_US   = 3_000;
  localparam int unsigned VOLT_PERIOD_US  = 63_000;
  localparam int unsigned SLEEP_CC_US     = 12_000;
  localparam int unsigned SECOND_US       = 1_000_000;
  localparam int unsigned WAKE_SETTLE_US  = 250_000;
  localparam int unsigned CUR_CYCLES      = CLK_HZ / 1_000_000 * CUR_PERIOD_US;
  localparam int unsigned VOLT_CYCLES     = CLK_HZ / 1_000_000 * VOLT_PERIOD_US;
  localparam int unsigned SLEEP_CC_CYCLES = CLK_HZ / 1_000_000 * SLEEP_CC_US;
  localparam int unsigned SECOND_CYCLES   = CLK_HZ / 1_000_000 * SECOND_US;
  localparam int unsigned SETTLE_CYCLES   = CLK_HZ / 1_000_000 * WAKE_SETTLE_US;
  localparam int unsigned FAST_OSC_KHZ    = 16_780;
  localparam int unsigned SLOW_FAST_KHZ   = 262;
  localparam int unsigned SLOW_SLOW_KHZ   = 32;

  // Register offsets
  localparam logic [3:0] REG_CONTROL   = 4'h0;
  localparam logic [3:0] REG_COMMAND   = 4'h1;
  localparam logic [3:0] REG_STATUS    = 4'h2;
  localparam logic [3:0] REG_RELAX_TH  = 4'h3;
  localparam logic [3:0] REG_WAKE_TH   = 4'h4;
  localparam logic [3:0] REG_PACK_DLT  = 4'h5;
  localparam logic [3:0] REG_STACK_TH  = 4'h6;
  localparam logic [3:0] REG_HYST      = 4'h7;
  localparam logic [3:0] REG_INTERVAL  = 4'h8;

  // Control field positions
  localparam int unsigned CTL_SLEEP_EN   = 0;
  localparam int unsigned CTL_FAST_CONV  = 1;
  localparam int unsigned CTL_CHG_SLEEP  = 2;
  localparam int unsigned CTL_DSG_FOLLOW = 3;
  localparam int unsigned CTL_AUX_REGULATOR_ONE_KEEP  = 4;
  localparam int unsigned CTL_AUX_REGULATOR_TWO_KEEP  = 5;
  localparam int unsigned CTL_SLOW_KEEP  = 6;
  localparam int unsigned CTL_VOLT_DIV   = 8;
  localparam logic [15:0] CONTROL_RESET  = 16'h0031;

  // Subcommand codes written to the command register
  localparam logic [7:0] CMD_SLEEP_ALLOW    = 8'h01;
  localparam logic [7:0] CMD_SLEEP_DISALLOW = 8'h02;
  localparam logic [7:0] CMD_SLEEP_EXIT     = 8'h03;
  localparam logic [7:0] CMD_DEEP_ENTER     = 8'h04;
  localparam logic [7:0] CMD_DEEP_EXIT      = 8'h05;
  localparam logic [7:0] CMD_SHUTDOWN       = 8'h06;
  localparam logic [7:0] CMD_CFG_ENTER      = 8'h07;
  localparam logic [7:0] CMD_CFG_EXIT       = 8'h08;

  localparam logic [15:0] RELAX_TH_RESET = 16'h000A;
  localparam logic [15:0] WAKE_TH_RESET  = 16'h0014;
  localparam logic [15:0] PACK_DLT_RESET = 16'h0064;
  localparam logic [15:0] STACK_TH_RESET = 16'h2000;
  localparam logic [15:0] HYST_RESET     = 16'h000A;
  localparam logic [15:0] INTERVAL_RESET = 16'h0001;

  typedef enum logic [5:0] {
    BMPM_NORMAL   = 6'b00_0001,
    BMPM_SLEEP    = 6'b00_0010,
    BMPM_DEEP     = 6'b00_0100,
    BMPM_WAKING   = 6'b00_1000,
    BMPM_SHUTDOWN = 6'b01_0000,
    BMPM_CONFIG   = 6'b10_0000
  } bmpm_mode_t;
endpackage : bmpm_pkg

/* bmpm_power_modes.sv */
// Power-mode controller: mode sequencing, measurement cadence, FET gating
// How it works
// [RL1] Fast oscillator at 16.78 MHz, locked, on only when needed.
// [RL2] Four power modes plus config mode, by host or autonomous.
// [RL3] Sleep: discharge FET on, charge FET optional, protections on.
// [RL4] Deep mode: all four FETs, protections, measurements off.
// [RL5] Shutdown: regulators, FETs, protections, measurements off.
// [RL6] Normal: current every 3 ms, voltages every 63 ms or slower.
// [RL7] Control bit doubles voltage and fast current rate.
// [RL8] Fine current below relax threshold enters sleep if allowed.
// [RL9] Sleep permission from reset bit, then commands; status shows it.
// [RL10] Sleep: comparators as normal, ADC readings per interval.
// [RL11] Sleep exits on fault, current, charger, command, short pin.
// [RL12] Current exit: FETs at once, loop restarts at next second.
// [RL13] Sleep samples current every 12 ms against wake threshold.
// [RL14] Sleep exits if pack over stack by delta while stack low.
// [RL15] Sleep re-entry blocked for hysteresis seconds after exit.
// [RL16] Sleep: discharge FET pump or follower, charge FET per setting.
// [RL17] Deep mode entered only by host command.
// [RL18] Deep exits on command, short pin pulse or load pin rise.
// [RL19] Deep goes to shutdown on low supply.
// [RL20] Deep exit: settle about 250 ms and a full loop first.
// [RL21] Deep keeps regulators and slow oscillator per configuration.
// [RL22] Deep ignores writes except the command register.
// [RL23] Pin high resets logic; held one second means shutdown.
// [RL24] Slow oscillator 262.144 kHz in normal, 32.768 kHz sleeping.
// [RL25] Shutdown wins over wake; one decision per tick.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module bmpm_power_modes
  import bmpm_pkg::*;
#(
  parameter int unsigned SECOND_CNT = SECOND_CYCLES,
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
  parameter int unsigned CUR_CNT    = CUR_CYCLES,
  parameter int unsigned CC_CNT     = SLEEP_CC_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        reset_shutdown_pin,
  input  wire logic        protection_fault,
  input  wire logic        charger_attach,
  input  wire logic        load_above_wake,
  input  wire logic        supply_below_hysteresis,
  input  wire logic [15:0] fine_current_reading,
  input  wire logic [15:0] sleep_current_sample,
  input  wire logic [15:0] pack_voltage,
  input  wire logic [15:0] stack_voltage,
  input  wire logic        loop_done,
  output logic             charge_fet,
  output logic             precharge_fet,
  output logic             discharge_fet,
  output logic             predischarge_fet,
  output logic             discharge_follower,
  output logic             protections_on,
  output logic             current_strobe,
  output logic             voltage_strobe,
  output logic             cc_sample_strobe,
  output logic             fast_conversion,
  output logic             aux_regulator_one,
  output logic             aux_regulator_two,
  output logic             main_regulator,
  output logic             slow_oscillator,
  output logic             slow_oscillator_low_rate,
  output logic             fast_oscillator,
  output logic             logic_reset
);
  bmpm_mode_t  mode;
  logic [15:0] control;
  logic [15:0] relax_th;
  logic [15:0] wake_th;
  logic [15:0] pack_dlt;
  logic [15:0] stack_th;
  logic [15:0] hyst;
  logic [15:0] interval;
  logic        sleep_allowed;
  logic [31:0] pin_cnt;
  logic        pin_long;
  logic        pin_short;
  logic        pin_prev;
  logic        load_prev;
  logic [31:0] sec_cnt;
  logic        sec_tick;
  logic [15:0] hyst_cnt;
  logic [15:0] ivl_cnt;
  logic        ivl_tick;
  logic [31:0] cur_cnt;
  logic [7:0]  volt_cnt;
  logic [31:0] cc_cnt;
  logic [31:0] settle_cnt;
  logic        settled;
  logic        loop_seen;
  logic        loop_hold;
  logic        measure_ok;
  logic        cmd_wr;
  logic [15:0] fine_mag;
  logic [15:0] cc_mag;
  logic        cur_flow;
  logic        pack_wake;
  logic        shut_req;

  assign cmd_wr   = wr && (addr == REG_COMMAND);
  assign fine_mag = fine_current_reading[15] ? 16'(-fine_current_reading)
                                             : fine_current_reading;
  assign cc_mag   = sleep_current_sample[15] ? 16'(-sleep_current_sample)
                                             : sleep_current_sample;
  // Pulse of the pin ended before one second elapsed
  assign pin_short = pin_prev && !reset_shutdown_pin && !pin_long;
  assign sec_tick  = (sec_cnt == SECOND_CNT - 1);
  assign ivl_tick  = sec_tick && (ivl_cnt >= interval - 16'h0001);
  assign cur_flow  = (cc_sample_strobe && (cc_mag > wake_th)) ||
                     (ivl_tick && (fine_mag > wake_th)); // [RL13]
  assign pack_wake = ivl_tick && (pack_voltage > stack_voltage) &&
                     (16'(pack_voltage - stack_voltage) > pack_dlt) &&
                     (stack_voltage < stack_th); // [RL14]
  assign shut_req  = pin_long ||
                     (cmd_wr && wdata[7:0] == CMD_SHUTDOWN) ||
                     (mode == BMPM_DEEP && supply_below_hysteresis); // [RL19]
  assign measure_ok = (mode == BMPM_NORMAL) && !loop_hold;

  // Configuration registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      control  <= CONTROL_RESET;
      relax_th <= RELAX_TH_RESET;
      wake_th  <= WAKE_TH_RESET;
      pack_dlt <= PACK_DLT_RESET;
      stack_th <= STACK_TH_RESET;
      hyst     <= HYST_RESET;
      interval <= INTERVAL_RESET;
    end else if (wr && mode != BMPM_DEEP) begin // [RL22]
      unique case (addr)
        REG_CONTROL:  control  <= wdata;
        REG_RELAX_TH: relax_th <= wdata;
        REG_WAKE_TH:  wake_th  <= wdata;
        REG_PACK_DLT: pack_dlt <= wdata;
        REG_STACK_TH: stack_th <= wdata;
        REG_HYST:     hyst     <= wdata;
        REG_INTERVAL: interval <= (wdata == 16'h0000) ? 16'h0001 : wdata;
        default: ;
      endcase
    end
  end

  // Sleep permission: power-up bit, then subcommands
  always_ff @(posedge clock) begin
    if (sys_rst)
      sleep_allowed <= CONTROL_RESET[CTL_SLEEP_EN]; // [RL9]
    else if (cmd_wr && mode != BMPM_DEEP) begin
      if (wdata[7:0] == CMD_SLEEP_ALLOW)
        sleep_allowed <= 1'b1; // [RL9]
      else if (wdata[7:0] == CMD_SLEEP_DISALLOW)
        sleep_allowed <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      rdata <= 16'h0000;
    else if (rd) begin
      unique case (addr)
        REG_CONTROL:  rdata <= control;
        REG_STATUS:   rdata <= {8'h00, mode,
                                (mode == BMPM_SLEEP), sleep_allowed}; // [RL9]
        REG_RELAX_TH: rdata <= relax_th;
        REG_WAKE_TH:  rdata <= wake_th;
        REG_PACK_DLT: rdata <= pack_dlt;
        REG_STACK_TH: rdata <= stack_th;
        REG_HYST:     rdata <= hyst;
        REG_INTERVAL: rdata <= interval;
        default:      rdata <= 16'h0000;
      endcase
    end else
      rdata <= 16'h0000;
  end

  // Reset/shutdown pin timing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_cnt   <= 32'h0000_0000;
      pin_long  <= 1'b0;
      pin_prev  <= 1'b0;
      load_prev <= 1'b0;
    end else begin
      pin_prev  <= reset_shutdown_pin;
      load_prev <= load_above_wake;
      if (!reset_shutdown_pin) begin
        pin_cnt  <= 32'h0000_0000;
        pin_long <= 1'b0;
      end else if (pin_cnt == SECOND_CNT - 1)
        pin_long <= 1'b1; // [RL23]
      else
        pin_cnt <= pin_cnt + 32'h0000_0001;
    end
  end

  // One-second timebase, interval and hysteresis counters
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sec_cnt  <= 32'h0000_0000;
      ivl_cnt  <= 16'h0000;
      hyst_cnt <= 16'h0000;
    end else begin
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      if (mode != BMPM_SLEEP)
        ivl_cnt <= 16'h0000;
      else if (sec_tick)
        ivl_cnt <= ivl_tick ? 16'h0000 : ivl_cnt + 16'h0001; // [RL10]
      if (mode == BMPM_SLEEP)
        hyst_cnt <= hyst; // [RL15]
      else if (sec_tick && hyst_cnt != 16'h0000)
        hyst_cnt <= hyst_cnt - 16'h0001;
    end
  end

  // Mode sequencer, one decision per clock
  always_ff @(posedge clock) begin
    if (sys_rst)
      mode <= BMPM_NORMAL;
    else if (shut_req)
      mode <= BMPM_SHUTDOWN; // [RL25] [RL5]
    else begin
      unique case (mode)
        BMPM_NORMAL: begin
          if (cmd_wr && wdata[7:0] == CMD_DEEP_ENTER)
            mode <= BMPM_DEEP; // [RL17]
          else if (cmd_wr && wdata[7:0] == CMD_CFG_ENTER)
            mode <= BMPM_CONFIG; // [RL2]
          else if (sleep_allowed && hyst_cnt == 16'h0000 &&
                   fine_mag < relax_th && !protection_fault &&
                   !charger_attach && !reset_shutdown_pin)
            mode <= BMPM_SLEEP; // [RL8]
        end
        BMPM_SLEEP: begin
          if (protection_fault || cur_flow || charger_attach ||
              pack_wake || pin_short || !sleep_allowed ||
              (cmd_wr && wdata[7:0] == CMD_SLEEP_EXIT))
            mode <= BMPM_NORMAL; // [RL11]
          else if (cmd_wr && wdata[7:0] == CMD_DEEP_ENTER)
            mode <= BMPM_DEEP;
        end
        BMPM_DEEP: begin
          if ((cmd_wr && wdata[7:0] == CMD_DEEP_EXIT) || pin_short ||
              (load_above_wake && !load_prev))
            mode <= BMPM_WAKING; // [RL18]
        end
        BMPM_WAKING: begin
          if (settled && loop_seen && !protection_fault)
            mode <= BMPM_NORMAL; // [RL20]
        end
        BMPM_CONFIG: begin
          if (cmd_wr && wdata[7:0] == CMD_CFG_EXIT)
            mode <= BMPM_NORMAL;
        end
        BMPM_SHUTDOWN: mode <= BMPM_SHUTDOWN;
      endcase
    end
  end

  // Wake settle from deep mode and measurement-loop restart hold
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      settle_cnt <= 32'h0000_0000;
      settled    <= 1'b0;
      loop_seen  <= 1'b0;
      loop_hold  <= 1'b0;
    end else begin
      if (mode != BMPM_WAKING) begin
        settle_cnt <= 32'h0000_0000;
        settled    <= 1'b0;
        loop_seen  <= 1'b0;
      end else begin
        if (settle_cnt == SETTLE_CNT - 1)
          settled <= 1'b1; // [RL20]
        else
          settle_cnt <= settle_cnt + 32'h0000_0001;
        if (loop_done)
          loop_seen <= 1'b1;
      end
      if (mode == BMPM_SLEEP && cur_flow)
        loop_hold <= 1'b1; // [RL12]
      else if (sec_tick)
        loop_hold <= 1'b0;
    end
  end

  // Measurement cadence
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_cnt          <= 32'h0000_0000;
      volt_cnt         <= 8'h00;
      cc_cnt           <= 32'h0000_0000;
      current_strobe   <= 1'b0;
      voltage_strobe   <= 1'b0;
      cc_sample_strobe <= 1'b0;
    end else begin
      current_strobe   <= 1'b0;
      voltage_strobe   <= 1'b0;
      cc_sample_strobe <= 1'b0;
      if (!measure_ok) begin
        cur_cnt  <= 32'h0000_0000;
        volt_cnt <= 8'h00; // [RL4] [RL12]
      end else if (cur_cnt >= (control[CTL_FAST_CONV] ? CUR_CNT / 2 - 1
                                                      : CUR_CNT - 1)) begin
        cur_cnt        <= 32'h0000_0000; // [RL6] [RL7]
        current_strobe <= 1'b1;
        if (volt_cnt >= {2'b00, control[CTL_VOLT_DIV +: 5], 1'b0} + 8'd20) begin
          volt_cnt       <= 8'h00; // [RL6]
          voltage_strobe <= 1'b1;
        end else
          volt_cnt <= volt_cnt + 8'h01;
      end else
        cur_cnt <= cur_cnt + 32'h0000_0001;
      if (mode != BMPM_SLEEP || cc_cnt == CC_CNT - 1) begin
        cc_cnt           <= 32'h0000_0000;
        cc_sample_strobe <= (mode == BMPM_SLEEP); // [RL13]
      end else
        cc_cnt <= cc_cnt + 32'h0000_0001;
      if (ivl_tick && mode == BMPM_SLEEP) begin
        current_strobe <= 1'b1; // [RL10]
        voltage_strobe <= 1'b1;
      end
    end
  end

  // FET, protection, regulator and oscillator outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      charge_fet               <= 1'b0;
      precharge_fet            <= 1'b0;
      discharge_fet            <= 1'b0;
      predischarge_fet         <= 1'b0;
      discharge_follower       <= 1'b0;
      protections_on           <= 1'b0;
      fast_conversion          <= 1'b0;
      aux_regulator_one        <= 1'b0;
      aux_regulator_two        <= 1'b0;
      main_regulator           <= 1'b1;
      slow_oscillator          <= 1'b1;
      slow_oscillator_low_rate <= 1'b0;
      fast_oscillator          <= 1'b1;
      logic_reset              <= 1'b0;
    end else begin
      logic_reset     <= reset_shutdown_pin; // [RL23]
      fast_conversion <= control[CTL_FAST_CONV]; // [RL7]
      unique case (mode)
        BMPM_NORMAL, BMPM_CONFIG: begin
          charge_fet         <= !protection_fault;
          precharge_fet      <= 1'b0;
          discharge_fet      <= !protection_fault;
          predischarge_fet   <= 1'b0;
          discharge_follower <= 1'b0;
          protections_on     <= (mode == BMPM_NORMAL); // [RL6]
          aux_regulator_one  <= control[CTL_AUX_REGULATOR_ONE_KEEP];
          aux_regulator_two  <= control[CTL_AUX_REGULATOR_TWO_KEEP];
          main_regulator     <= 1'b1;
          slow_oscillator    <= 1'b1;
          slow_oscillator_low_rate <= 1'b0; // [RL24]
          fast_oscillator    <= measure_ok || cmd_wr; // [RL1]
        end
        BMPM_SLEEP: begin
          charge_fet         <= control[CTL_CHG_SLEEP]; // [RL3] [RL16]
          precharge_fet      <= 1'b0;
          discharge_fet      <= 1'b1; // [RL3]
          predischarge_fet   <= 1'b0;
          discharge_follower <= control[CTL_DSG_FOLLOW]; // [RL16]
          protections_on     <= 1'b1; // [RL10]
          slow_oscillator    <= 1'b1;
          slow_oscillator_low_rate <= 1'b1; // [RL24]
          fast_oscillator    <= ivl_tick || cc_sample_strobe; // [RL1]
        end
        BMPM_DEEP, BMPM_WAKING: begin
          charge_fet         <= 1'b0; // [RL4]
          precharge_fet      <= 1'b0;
          discharge_fet      <= 1'b0;
          predischarge_fet   <= 1'b0;
          discharge_follower <= 1'b0;
          protections_on     <= (mode == BMPM_WAKING);
          slow_oscillator    <= control[CTL_SLOW_KEEP] ||
                                (mode == BMPM_WAKING); // [RL21]
          slow_oscillator_low_rate <= 1'b1; // [RL24]
          fast_oscillator    <= (mode == BMPM_WAKING);
        end
        BMPM_SHUTDOWN: begin
          charge_fet         <= 1'b0; // [RL5]
          precharge_fet      <= 1'b0;
          discharge_fet      <= 1'b0;
          predischarge_fet   <= 1'b0;
          discharge_follower <= 1'b0;
          protections_on     <= 1'b0;
          aux_regulator_one  <= 1'b0;
          aux_regulator_two  <= 1'b0;
          main_regulator     <= 1'b0;
          slow_oscillator    <= 1'b0;
          fast_oscillator    <= 1'b0;
        end
      endcase
    end
  end
endmodule : bmpm_power_modes
`default_nettype wire

/* bmpm_host.sv */
// Host model: register port master of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module bmpm_host
  import bmpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [15:0] rdata,
  output logic      [3:0]  addr,
  output logic      [15:0] wdata,
  output logic             wr,
  output logic             rd
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : write_reg

  // Read data only stands in the cycle after the strobe
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : read_reg

  // Deep mode is only ever requested from here
  task automatic send_cmd(input logic [7:0] c);
    write_reg(REG_COMMAND, {8'h00, c});
  endtask : send_cmd
endmodule : bmpm_host
`default_nettype wire

/* bmpm_checker.sv */
// Port assertions for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module bmpm_checker
  import bmpm_pkg::*;
#(
  parameter int unsigned SECOND_CNT = SECOND_CYCLES,
  parameter int unsigned CUR_CNT    = CUR_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_shutdown_pin,
  input wire logic charge_fet,
  input wire logic precharge_fet,
  input wire logic discharge_fet,
  input wire logic predischarge_fet,
  input wire logic protections_on,
  input wire logic current_strobe,
  input wire logic voltage_strobe,
  input wire logic cc_sample_strobe,
  input wire logic fast_conversion,
  input wire logic aux_regulator_one,
  input wire logic aux_regulator_two,
  input wire logic main_regulator,
  input wire logic slow_oscillator_low_rate,
  input wire logic logic_reset
);
  int unsigned pin_cnt;
  int unsigned gap;
  int unsigned steady;
  logic [4:0]  cond;
  logic [4:0]  cond_q;

  assign cond = {protections_on, slow_oscillator_low_rate, fast_conversion,
                 main_regulator, logic_reset};

  always_ff @(posedge clock) begin
    if (sys_rst || !reset_shutdown_pin) pin_cnt <= 0;
    else if (pin_cnt < SECOND_CNT + 9) pin_cnt <= pin_cnt + 1;
  end

  // Strobe gaps are judged only if no mode output moved since the last one
  always_ff @(posedge clock) begin
    if (sys_rst || current_strobe) gap <= 1;
    else if (gap < 100_000) gap <= gap + 1;
  end

  always_ff @(posedge clock) begin
    cond_q <= cond;
    if (sys_rst || cond != cond_q) steady <= 0;
    else if (steady < 100_000) steady <= steady + 1;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_pin_rise;
    !reset_shutdown_pin ##1 reset_shutdown_pin;
  endsequence
  sequence s_pin_held;
    pin_cnt == SECOND_CNT + 6;
  endsequence

  a_shut_power_off: assert property (
    !main_regulator |-> !aux_regulator_one && !aux_regulator_two
      && !protections_on)
    else $error("power left on in shutdown");
  a_shut_sticky: assert property (
    !main_regulator |=> !main_regulator)
    else $error("shutdown left without reset");
  a_shut_no_meas: assert property (
    !main_regulator |-> !current_strobe && !voltage_strobe
      && !cc_sample_strobe)
    else $error("conversion in shutdown");
  a_off_fets_low: assert property (
    !protections_on |-> !charge_fet && !precharge_fet && !discharge_fet
      && !predischarge_fet)
    else $error("fet on with protections off");
  a_pin_reset_now: assert property (
    s_pin_rise |-> ##[1:2] logic_reset)
    else $error("pin did not reset logic");
  a_pin_hold_off: assert property (
    s_pin_held |-> !main_regulator)
    else $error("held pin did not shut down");
  a_cur_cadence: assert property (
    current_strobe && steady > gap && protections_on
      && !slow_oscillator_low_rate && !fast_conversion |-> gap == CUR_CNT)
    else $error("current strobe period wrong");
  a_cur_pulse: assert property (
    current_strobe |=> !current_strobe)
    else $error("current strobe too long");
  a_cc_in_sleep: assert property (
    cc_sample_strobe |-> discharge_fet && protections_on
      && slow_oscillator_low_rate)
    else $error("sleep sample outside sleep");
endmodule : bmpm_checker

bind bmpm_power_modes bmpm_checker #(
  .SECOND_CNT(SECOND_CNT), .CUR_CNT(CUR_CNT)
) bmpm_checker_i (.*);
`default_nettype wire

/* bmpm_power_modes_tb.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
`default_nettype none
module bmpm_power_modes_tb import bmpm_pkg::*;;
  localparam int SEC = 200;
  logic        clock, sys_rst, reset_shutdown_pin, protection_fault;
  logic        charger_attach, load_above_wake, supply_below_hysteresis;
  logic        loop_done, wr, rd;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, fine_current_reading, sleep_current_sample;
  logic [15:0] pack_voltage, stack_voltage;
  logic        charge_fet, precharge_fet, discharge_fet, predischarge_fet;
  logic        discharge_follower, protections_on, current_strobe;
  logic        voltage_strobe, cc_sample_strobe, fast_conversion;
  logic        aux_regulator_one, aux_regulator_two, main_regulator;
  logic        slow_oscillator, slow_oscillator_low_rate, fast_oscillator;
  logic        logic_reset;
  int          err_count, samples_checked;
  logic [3:0]  ra [9] = '{REG_CONTROL, REG_STATUS, REG_RELAX_TH, REG_WAKE_TH,
    REG_PACK_DLT, REG_STACK_TH, REG_HYST, REG_INTERVAL, 4'hF};
  logic [15:0] rv [9] = '{CONTROL_RESET, 16'h0005, RELAX_TH_RESET,
    WAKE_TH_RESET, PACK_DLT_RESET, STACK_TH_RESET, HYST_RESET,
    INTERVAL_RESET, 16'h0000};

  bmpm_power_modes #(
    .SECOND_CNT(SEC), .SETTLE_CNT(50), .CUR_CNT(20), .CC_CNT(30)
  ) bmpm_power_modes_i (.*);
  bmpm_host bmpm_host_i (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic report_and_stop();
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic chk1(input string nm, input logic seen, exp);
    check(nm, 16'(seen), 16'(exp));
  endtask : chk1

  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    bmpm_host_i.read_reg(a, d);
    check("register", d, exp);
  endtask : rdchk

  // Polls status until the one-hot mode field shows m or n reads pass
  task automatic wait_mode(input logic [5:0] m, input int n);
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < n && s[7:2] !== m; k++)
      bmpm_host_i.read_reg(REG_STATUS, s);
    check("mode", 16'(s[7:2]), 16'(m));
  endtask : wait_mode

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic do_reset();
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
  endtask : do_reset

  initial begin
    #2_000_000;
    err_count++;
    report_and_stop();
  end

  initial begin
    sys_rst = 1'b1;
    reset_shutdown_pin = 1'b0;
    protection_fault = 1'b0;
    charger_attach = 1'b0;
    load_above_wake = 1'b0;
    supply_below_hysteresis = 1'b0;
    loop_done = 1'b0;
    fine_current_reading = 16'h0100;
    sleep_current_sample = 16'h0000;
    pack_voltage = 16'h1000;
    stack_voltage = 16'h3000;
    do_reset();
    for (int i = 0; i < 9; i++)
      rdchk(ra[i], rv[i]);
    bmpm_host_i.write_reg(REG_CONTROL, CONTROL_RESET | 16'h0002);
    tick(3);
    chk1("fast_conversion", fast_conversion, 1'b1);
    bmpm_host_i.write_reg(REG_CONTROL, CONTROL_RESET);
    bmpm_host_i.write_reg(REG_HYST, 16'h0002);
    fine_current_reading <= 16'h0000;
    wait_mode(BMPM_SLEEP, 20);
    rdchk(REG_STATUS, 16'h000B);
    chk1("discharge_fet", discharge_fet, 1'b1);
    chk1("charge_fet", charge_fet, 1'b0);
    chk1("slow_oscillator_low_rate", slow_oscillator_low_rate, 1'b1);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: sleep_current_sample <= 16'h0064;
        1: protection_fault <= 1'b1;
        2: charger_attach <= 1'b1;
        3: bmpm_host_i.send_cmd(CMD_SLEEP_EXIT);
        default: begin
          pack_voltage <= 16'h1800;
          stack_voltage <= 16'h1000;
        end
      endcase
      wait_mode(BMPM_NORMAL, 300);
      if (i == 0)
        chk1("charge_fet", charge_fet, 1'b1);
      sleep_current_sample <= 16'h0000;
      protection_fault <= 1'b0;
      charger_attach <= 1'b0;
      pack_voltage <= 16'h1000;
      stack_voltage <= 16'h3000;
      tick(150);
      wait_mode(BMPM_NORMAL, 1);
      wait_mode(BMPM_SLEEP, 400);
    end
    bmpm_host_i.send_cmd(CMD_SLEEP_DISALLOW);
    wait_mode(BMPM_NORMAL, 10);
    rdchk(REG_STATUS, 16'h0004);
    tick(700);
    wait_mode(BMPM_NORMAL, 1);
    fine_current_reading <= 16'h0100;
    bmpm_host_i.send_cmd(CMD_SLEEP_ALLOW);
    rdchk(REG_STATUS, 16'h0005);
    for (int j = 0; j < 3; j++) begin
      bmpm_host_i.send_cmd(CMD_DEEP_ENTER);
      wait_mode(BMPM_DEEP, 5);
      chk1("protections_on", protections_on, 1'b0);
      chk1("aux_regulator_two", aux_regulator_two, 1'b1);
      chk1("slow_oscillator", slow_oscillator, 1'b0);
      bmpm_host_i.write_reg(REG_HYST, 16'h0009);
      rdchk(REG_HYST, 16'h0002);
      case (j)
        0: bmpm_host_i.send_cmd(CMD_DEEP_EXIT);
        1: load_above_wake <= 1'b1;
        default: reset_shutdown_pin <= 1'b1;
      endcase
      tick(3);
      load_above_wake <= 1'b0;
      reset_shutdown_pin <= 1'b0;
      wait_mode(BMPM_WAKING, 5);
      tick(60);
      wait_mode(BMPM_WAKING, 1);
      loop_done <= 1'b1;
      tick(1);
      loop_done <= 1'b0;
      wait_mode(BMPM_NORMAL, 5);
    end
    bmpm_host_i.send_cmd(CMD_DEEP_ENTER);
    wait_mode(BMPM_DEEP, 5);
    supply_below_hysteresis <= 1'b1;
    load_above_wake <= 1'b1;
    tick(4);
    chk1("main_regulator", main_regulator, 1'b0);
    chk1("aux_regulator_one", aux_regulator_one, 1'b0);
    supply_below_hysteresis <= 1'b0;
    load_above_wake <= 1'b0;
    do_reset();
    reset_shutdown_pin <= 1'b1;
    tick(3);
    chk1("logic_reset", logic_reset, 1'b1);
    tick(SEC + 4);
    chk1("main_regulator", main_regulator, 1'b0);
    chk1("discharge_fet", discharge_fet, 1'b0);
    reset_shutdown_pin <= 1'b0;
    do_reset();
    wait_mode(BMPM_NORMAL, 2);
    report_and_stop();
  end
endmodule : bmpm_power_modes_tb
`default_nettype wire
